// >>> include/gpe_consts.svh
// Register offsets, pin and line counts and reset values for the GPIO port with edge event unit.
// Assumes inclusion by bare name from the package and the design file.
`ifndef GPE_CONSTS_SVH
`define GPE_CONSTS_SVH
`define GPE_PINS           16
`define GPE_LINES          20
`define GPE_INT_LINES      4
`define GPE_ADDR_W         8
`define GPE_MODE_OFS       8'h00
`define GPE_MODE_HI_OFS    8'h04
`define GPE_IN_OFS         8'h08
`define GPE_OUT_OFS        8'h0c
`define GPE_BSR_OFS        8'h10
`define GPE_RISE_OFS       8'h14
`define GPE_FALL_OFS       8'h18
`define GPE_LMASK_OFS      8'h1c
`define GPE_EMASK_OFS      8'h20
`define GPE_SWTRIG_OFS     8'h24
`define GPE_PEND_OFS       8'h28
`define GPE_SEL_LO_OFS     8'h2c
`define GPE_SEL_HI_OFS     8'h30
`define GPE_IMASK_OFS      8'h34
`define GPE_ISTAT_OFS      8'h38
`define GPE_MODE_RST       32'h0000_0000
`define GPE_OUT_RST        16'h0000
`endif

// >>> include/gpe_pkg.sv
// Types for the GPIO port with edge event unit.
// Assumes the constants header is on the include path.
`include "gpe_consts.svh"
package gpe_pkg;
    // Eight pin modes, three bits per pin in the mode registers
    typedef enum logic [2:0] {
        GPE_M_ANALOG,
        GPE_M_FLOAT,
        GPE_M_PULL_UP,
        GPE_M_PULL_DOWN,
        GPE_M_OUT_OD,
        GPE_M_OUT_PP,
        GPE_M_AF_OD,
        GPE_M_AF_PP
    } gpe_mode_t;
endpackage

// >>> rtl/gpe_port.sv
// GPIO port of 16 pins with pin modes, set/reset output control and a 20-line edge event unit.
// Assumes an APB master on clk; pads, alternate-function outputs and internal wake sources come from outside.
`timescale 1ns/1ps
`include "gpe_consts.svh"

// How it works
// R1: Every clock, the synchronised pad level is captured into the input register.
// R2: Input modes disable the driver; pull-up or pull-down follows the mode.
// R3: Output modes turn pulls off, enable the driver, keep the receiver on.
// R4: Open-drain: bit 0 drives low, bit 1 releases the pad.
// R5: Push-pull: bit 0 drives low, bit 1 drives high.
// R6: Reading the output register returns the last value written.
// R7: Reading the input register returns the pad level, not the driven value.
// R8: Each pin has eight selectable modes held in three-bit fields.
// R9: Set/reset register changes chosen output bits and leaves the rest alone.
// R10: Twenty independent detectors raise interrupt requests or wake events.
// R11: Each line triggers on rising, falling, or both edges.
// R12: Each line has its own edge enables and interrupt and event masks.
// R13: Lines 0 to 15 come from pins; 16 to 19 are internal sources.
// R14: Line source select registers route any port pin to a pin-fed line.
// R15: Software trigger register raises a line without any pin edge.
// R16: Unmasked event lines drive a wake pulse out of the block.
// R17: An enabled falling-edge line turns a high-to-low pin transition into a request.
// R18: Each line compares with its previous sample and latches pending until cleared.
module gpe_port
    import gpe_pkg::*;
(
    input  wire logic                          clk,
    input  wire logic                          rst_n,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [`GPE_ADDR_W-1:0]        paddr,
    input  wire logic [31:0]                   pwdata,
    output logic      [31:0]                   prdata,
    output logic                               pready,
    output logic                               pslverr,
    input  wire logic [`GPE_PINS-1:0]          pad_in,
    output logic      [`GPE_PINS-1:0]          pad_out,
    output logic      [`GPE_PINS-1:0]          pad_oe,
    output logic      [`GPE_PINS-1:0]          pad_pull_up,
    output logic      [`GPE_PINS-1:0]          pad_pull_down,
    output logic      [`GPE_PINS-1:0]          pad_rx_en,
    input  wire logic [`GPE_PINS-1:0]          af_out,
    input  wire logic                          low_voltage_detect,
    input  wire logic                          rtc_alarm,
    input  wire logic                          usb_wakeup,
    input  wire logic                          eth_wakeup,
    output logic      [`GPE_LINES-1:0]         line_irq,
    output logic                               wake_event,
    output logic                               irq
);
    logic [`GPE_PINS-1:0]      pad_meta_reg;
    logic [`GPE_PINS-1:0]      pad_sync_reg;
    logic [`GPE_INT_LINES-1:0] src_meta_reg;
    logic [`GPE_INT_LINES-1:0] src_sync_reg;
    logic [`GPE_PINS-1:0]      in_reg;
    logic [`GPE_PINS-1:0]      out_reg;
    logic [`GPE_PINS-1:0]      out_next;
    logic [47:0]               mode_reg;
    logic [`GPE_LINES-1:0]     rise_reg;
    logic [`GPE_LINES-1:0]     fall_reg;
    logic [`GPE_LINES-1:0]     lmask_reg;
    logic [`GPE_LINES-1:0]     emask_reg;
    logic [`GPE_LINES-1:0]     pend_reg;
    logic [`GPE_LINES-1:0]     pend_next;
    logic [`GPE_LINES-1:0]     line_prev_reg;
    logic [`GPE_LINES-1:0]     line_now;
    logic [`GPE_LINES-1:0]     hit;
    logic [`GPE_LINES-1:0]     swtrig;
    logic [63:0]               sel_reg;
    logic [1:0]                imask_reg;
    logic [1:0]                istat_reg;
    logic [1:0]                istat_next;
    logic                      wr;
    logic                      rd;
    logic                      mapped;
    logic [31:0]               rdata_next;
    logic                      edge_seen;
    logic                      irq_seen;

    // Second-cycle answer: pready rises in the access phase, so every transfer has one wait state
    assign wr = psel && penable && pwrite && !pready;
    assign rd = psel && penable && !pwrite && !pready;

    always_comb begin
        mapped = 1'b1;
        rdata_next = 32'h0000_0000;
        case (paddr)
            `GPE_MODE_OFS:    rdata_next = {8'h00, mode_reg[23:0]};
            `GPE_MODE_HI_OFS: rdata_next = {8'h00, mode_reg[47:24]};
            `GPE_IN_OFS:      rdata_next = {16'h0000, in_reg};                          // [R7]
            `GPE_OUT_OFS:     rdata_next = {16'h0000, out_reg};                         // [R6]
            `GPE_BSR_OFS:     rdata_next = 32'h0000_0000;
            `GPE_RISE_OFS:    rdata_next = {12'h000, rise_reg};
            `GPE_FALL_OFS:    rdata_next = {12'h000, fall_reg};
            `GPE_LMASK_OFS:   rdata_next = {12'h000, lmask_reg};
            `GPE_EMASK_OFS:   rdata_next = {12'h000, emask_reg};
            `GPE_SWTRIG_OFS:  rdata_next = 32'h0000_0000;
            `GPE_PEND_OFS:    rdata_next = {12'h000, pend_reg};
            `GPE_SEL_LO_OFS:  rdata_next = sel_reg[31:0];
            `GPE_SEL_HI_OFS:  rdata_next = sel_reg[63:32];
            `GPE_IMASK_OFS:   rdata_next = {30'h0000_0000, imask_reg};
            `GPE_ISTAT_OFS:   rdata_next = {30'h0000_0000, istat_reg};
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !mapped;
            if (rd) begin
                prdata <= rdata_next;
            end
        end
    end

    // Pads and internal sources are asynchronous, so two stages before any use
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pad_meta_reg <= 16'h0000;
            pad_sync_reg <= 16'h0000;
            src_meta_reg <= 4'h0;
            src_sync_reg <= 4'h0;
        end else begin
            pad_meta_reg <= pad_in;
            pad_sync_reg <= pad_meta_reg;
            src_meta_reg <= {eth_wakeup, usb_wakeup, rtc_alarm, low_voltage_detect};
            src_sync_reg <= src_meta_reg;
        end
    end

    // Receiver stays on in every mode except analog, so reads see the pad in all digital modes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            in_reg <= 16'h0000;
        end else begin
            in_reg <= pad_sync_reg;                                                     // [R1] [R7]
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_reg <= {`GPE_MODE_RST, 16'h0000};
        end else if (wr && paddr == `GPE_MODE_OFS) begin
            mode_reg[23:0] <= pwdata[23:0];                                             // [R8]
        end else if (wr && paddr == `GPE_MODE_HI_OFS) begin
            mode_reg[47:24] <= pwdata[23:0];                                            // [R8]
        end
    end

    // Reset half of the set/reset word wins over its set half only where set is zero
    always_comb begin
        out_next = out_reg;
        if (wr && paddr == `GPE_OUT_OFS) begin
            out_next = pwdata[15:0];                                                    // [R6]
        end else if (wr && paddr == `GPE_BSR_OFS) begin
            out_next = (out_reg & ~pwdata[31:16]) | pwdata[15:0];                       // [R9]
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_reg <= `GPE_OUT_RST;
        end else begin
            out_reg <= out_next;
        end
    end

    // Pad control is registered so each pad output comes from a flip-flop
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pad_out <= 16'h0000;
            pad_oe <= 16'h0000;
            pad_pull_up <= 16'h0000;
            pad_pull_down <= 16'h0000;
            pad_rx_en <= 16'h0000;
        end else begin
            for (int i = 0; i < `GPE_PINS; i++) begin
                case (gpe_mode_t'(mode_reg[3*i +: 3]))
                    GPE_M_ANALOG: begin
                        pad_oe[i] <= 1'b0;
                        pad_out[i] <= 1'b0;
                        pad_pull_up[i] <= 1'b0;
                        pad_pull_down[i] <= 1'b0;
                        pad_rx_en[i] <= 1'b0;
                    end
                    GPE_M_FLOAT, GPE_M_PULL_UP, GPE_M_PULL_DOWN: begin
                        pad_oe[i] <= 1'b0;                                              // [R2]
                        pad_out[i] <= 1'b0;
                        pad_pull_up[i] <= (gpe_mode_t'(mode_reg[3*i +: 3]) == GPE_M_PULL_UP);
                        pad_pull_down[i] <= (gpe_mode_t'(mode_reg[3*i +: 3]) == GPE_M_PULL_DOWN);
                        pad_rx_en[i] <= 1'b1;
                    end
                    GPE_M_OUT_OD: begin
                        pad_oe[i] <= ~out_next[i];                                      // [R3] [R4]
                        pad_out[i] <= 1'b0;
                        pad_pull_up[i] <= 1'b0;
                        pad_pull_down[i] <= 1'b0;
                        pad_rx_en[i] <= 1'b1;
                    end
                    GPE_M_OUT_PP: begin
                        pad_oe[i] <= 1'b1;                                              // [R3] [R5]
                        pad_out[i] <= out_next[i];
                        pad_pull_up[i] <= 1'b0;
                        pad_pull_down[i] <= 1'b0;
                        pad_rx_en[i] <= 1'b1;
                    end
                    GPE_M_AF_OD: begin
                        pad_oe[i] <= ~af_out[i];                                        // [R4]
                        pad_out[i] <= 1'b0;
                        pad_pull_up[i] <= 1'b0;
                        pad_pull_down[i] <= 1'b0;
                        pad_rx_en[i] <= 1'b1;
                    end
                    default: begin
                        pad_oe[i] <= 1'b1;                                              // [R5]
                        pad_out[i] <= af_out[i];
                        pad_pull_up[i] <= 1'b0;
                        pad_pull_down[i] <= 1'b0;
                        pad_rx_en[i] <= 1'b1;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rise_reg <= 20'h00000;
            fall_reg <= 20'h00000;
            lmask_reg <= 20'h00000;
            emask_reg <= 20'h00000;
            sel_reg <= 64'h0000_0000_0000_0000;
            imask_reg <= 2'h0;
        end else if (wr) begin
            if (paddr == `GPE_RISE_OFS) rise_reg <= pwdata[19:0];                       // [R11] [R12]
            if (paddr == `GPE_FALL_OFS) fall_reg <= pwdata[19:0];                       // [R11] [R12]
            if (paddr == `GPE_LMASK_OFS) lmask_reg <= pwdata[19:0];                     // [R12]
            if (paddr == `GPE_EMASK_OFS) emask_reg <= pwdata[19:0];                     // [R12]
            if (paddr == `GPE_SEL_LO_OFS) sel_reg[31:0] <= pwdata;                      // [R14]
            if (paddr == `GPE_SEL_HI_OFS) sel_reg[63:32] <= pwdata;                     // [R14]
            if (paddr == `GPE_IMASK_OFS) imask_reg <= pwdata[1:0];
        end
    end

    // Four select bits per pin-fed line pick which port pin it watches
    always_comb begin
        for (int l = 0; l < `GPE_PINS; l++) begin
            line_now[l] = in_reg[sel_reg[4*l +: 4]];                                    // [R13] [R14]
        end
        line_now[19:16] = src_sync_reg;                                                 // [R13]
    end

    assign swtrig = (wr && paddr == `GPE_SWTRIG_OFS) ? pwdata[19:0] : 20'h00000;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            line_prev_reg <= 20'h00000;
        end else begin
            line_prev_reg <= line_now;
        end
    end

    assign hit = (rise_reg & line_now & ~line_prev_reg)                                 // [R11] [R18]
               | (fall_reg & ~line_now & line_prev_reg)                                 // [R17]
               | swtrig;                                                                // [R15]

    // New edge wins over a write-one clear in the same cycle
    assign pend_next = (wr && paddr == `GPE_PEND_OFS) ? ((pend_reg & ~pwdata[19:0]) | hit)
                                                      : (pend_reg | hit);               // [R18]

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_reg <= 20'h00000;
            line_irq <= 20'h00000;
            wake_event <= 1'b0;
        end else begin
            pend_reg <= pend_next;
            line_irq <= pend_next & lmask_reg;                                          // [R10] [R17]
            wake_event <= |(hit & emask_reg);                                           // [R16]
        end
    end

    assign edge_seen = |(hit & ~swtrig);
    assign irq_seen = |(pend_next & lmask_reg & ~pend_reg);

    // Summary status: bit 0 any hardware edge, bit 1 any new unmasked request
    always_comb begin
        istat_next = istat_reg;
        if (wr && paddr == `GPE_ISTAT_OFS) begin
            istat_next = istat_reg & ~pwdata[1:0];
        end
        istat_next = istat_next | {irq_seen, edge_seen};
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            istat_reg <= 2'h0;
            irq <= 1'b0;
        end else begin
            istat_reg <= istat_next;
            irq <= |(istat_next & imask_reg);
        end
    end
endmodule

// >>> testbench/gpe_pad_model.sv
// Pads, keys and external resistors on the far side of the GPIO port.
// Assumes keys pull a pin hard low; pins in EXT_PU carry an external pull-up.
`timescale 1ns/1ps
module gpe_pad_model #(
    parameter logic [15:0] EXT_PU = 16'h00ff
) (
    input  wire logic        clk,
    input  wire logic [15:0] pad_out,
    input  wire logic [15:0] pad_oe,
    input  wire logic [15:0] pad_pull_up,
    input  wire logic [15:0] pad_pull_down,
    input  wire logic [15:0] key_press,
    output logic      [15:0] pad_in
);
    // A pin nobody holds flips every cycle so no settled value can pass by luck
    logic [15:0] float_q = 16'h0000;
    always_ff @(posedge clk) begin
        float_q <= ~pad_in;
    end
    // Internal pull-down outweighs the external pull-up; a driven pad wins over both
    assign pad_in = ~key_press & ((pad_oe & pad_out)
        | (~pad_oe & (pad_pull_up | (~pad_pull_down & (EXT_PU | float_q)))));
endmodule

// >>> testbench/gpe_port_monitor.sv
// Checker for the GPIO port: APB handshake, pad control and pending line relations.
// Assumes it is bound to gpe_port and sees only that module's ports.
`timescale 1ns/1ps
`include "gpe_consts.svh"
module gpe_port_monitor (
    input wire logic                  clk,
    input wire logic                  rst_n,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [31:0]           prdata,
    input wire logic                  pready,
    input wire logic                  pslverr,
    input wire logic [`GPE_PINS-1:0]  af_out,
    input wire logic [`GPE_PINS-1:0]  pad_out,
    input wire logic [`GPE_PINS-1:0]  pad_oe,
    input wire logic [`GPE_PINS-1:0]  pad_pull_up,
    input wire logic [`GPE_PINS-1:0]  pad_pull_down,
    input wire logic [`GPE_PINS-1:0]  pad_rx_en,
    input wire logic [`GPE_LINES-1:0] line_irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    chk_ready_wait: assert property (psel && penable && !pready |=> pready) else $error("pready late");
    chk_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
    chk_err_with_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
    chk_rdata_hold: assert property ($changed(prdata) |-> $past(psel && penable && !pwrite))
        else $error("prdata changed outside a read");
    chk_drive_no_pull: assert property ((pad_oe & (pad_pull_up | pad_pull_down)) == 0)
        else $error("pull active while driving");
    chk_pull_exclusive: assert property ((pad_pull_up & pad_pull_down) == 0)
        else $error("both pulls active");
    chk_rx_when_drive: assert property ((pad_oe & ~pad_rx_en) == 0)
        else $error("receiver off while driving");
    chk_ctrl_by_write: assert property ($changed({pad_oe, pad_rx_en, pad_pull_up, pad_pull_down})
        |-> $past(psel && penable && pwrite) || $past(af_out) != $past(af_out, 2))
        else $error("pad control changed without a write");
    chk_out_by_write: assert property ($changed(pad_out)
        |-> $past(psel && penable && pwrite) || $past(af_out) != $past(af_out, 2))
        else $error("pad_out changed without cause");
    chk_pend_sticky: assert property ((|($past(line_irq) & ~line_irq))
        |-> $past(psel && penable && pwrite) || $past(psel && penable && pwrite, 2))
        else $error("line request dropped without a write");
endmodule
bind gpe_port gpe_port_monitor gpe_port_monitor_i (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .af_out(af_out), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pull_up(pad_pull_up),
    .pad_pull_down(pad_pull_down), .pad_rx_en(pad_rx_en), .line_irq(line_irq));

// >>> testbench/tb_gpe_port.sv
// Testbench for the GPIO port: APB register access, pad modes, edge lines and interrupts.
// Assumes the pad model on the pins and the checker bound to the design.
`timescale 1ns/1ps
`include "gpe_consts.svh"
module tb_gpe_port;
    logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, irq, pready, pslverr, wake_event;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic [15:0] pad_in, pad_out, pad_oe, pad_pu, pad_pd, pad_rx, key = 16'h0, af = 16'h0f0f;
    logic [19:0] line_irq;
    logic rtc = 1'b0, e;
    logic [7:0] eo, pu, pd, rx, dv;
    int fails = 0, checked = 0, wakes = 0, w0;
    always #12.5 clk = ~clk;
    always @(posedge clk) if (wake_event === 1'b1) wakes++;
    gpe_port gpe_port_i (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pull_up(pad_pu), .pad_pull_down(pad_pd),
        .pad_rx_en(pad_rx), .af_out(af), .low_voltage_detect(1'b0), .rtc_alarm(rtc), .usb_wakeup(1'b0),
        .eth_wakeup(1'b0), .line_irq(line_irq), .wake_event(wake_event), .irq(irq));
    gpe_pad_model gpe_pad_model_i (.clk(clk), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pull_up(pad_pu),
        .pad_pull_down(pad_pd), .key_press(key), .pad_in(pad_in));
    task automatic stop_test();
        if (fails == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        checked++;
        if (g !== x) begin
            fails++;
            $display("[ERR] %0t got %h exp %h", $time, g, x);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 20) begin
            fails++;
            stop_test();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m);
        apb(1'b0, a, 32'h0);
        chk(r & m, x);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    function automatic logic [31:0] fld(input int m);
        fld = 32'h0;
        for (int k = 0; k < 8; k++) fld |= 32'(m) << (3 * k);
    endfunction
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        rdc(`GPE_MODE_OFS, `GPE_MODE_RST, 32'hffffffff);
        rdc(`GPE_OUT_OFS, 32'(`GPE_OUT_RST), 32'hffffffff);
        rdc(8'hfc, 32'h0, 32'hffffffff);
        chk(32'(e), 32'h1);
        wr(`GPE_OUT_OFS, 32'h00aa);
        for (int m = 0; m < 8; m++) begin
            wr(`GPE_MODE_OFS, fld(m));
            rdc(`GPE_MODE_OFS, fld(m), 32'hffffffff);
            tick(2);
            eo = (m == 4) ? 8'h55 : (m == 6) ? ~af[7:0] : (m == 5 || m == 7) ? 8'hff : 8'h00;
            pu = (m == 2) ? 8'hff : 8'h00;
            pd = (m == 3) ? 8'hff : 8'h00;
            rx = (m == 0) ? 8'h00 : 8'hff;
            dv = (m == 5) ? 8'haa : (m == 7) ? af[7:0] : 8'h00;
            chk({pad_oe[7:0], pad_pu[7:0], pad_pd[7:0], pad_rx[7:0]}, {eo, pu, pd, rx});
            chk(32'(pad_out[7:0] & pad_oe[7:0]), 32'(dv));
        end
        wr(`GPE_MODE_OFS, fld(5));
        wr(`GPE_OUT_OFS, 32'h1234);
        tick(4);
        rdc(`GPE_OUT_OFS, 32'h1234, 32'hffffffff);
        rdc(`GPE_IN_OFS, 32'h34, 32'hff);
        wr(`GPE_MODE_OFS, fld(4));
        wr(`GPE_OUT_OFS, 32'h00aa);
        key <= 16'h0002;
        tick(6);
        rdc(`GPE_IN_OFS, 32'ha8, 32'hff);
        key <= 16'h0000;
        wr(`GPE_BSR_OFS, 32'h0002_0004);
        rdc(`GPE_OUT_OFS, 32'h00ac, 32'hffffffff);
        wr(`GPE_BSR_OFS, 32'h0001_0001);
        rdc(`GPE_OUT_OFS, 32'h00ad, 32'hffffffff);
        wr(`GPE_MODE_OFS, fld(1));
        wr(`GPE_SEL_LO_OFS, 32'h3);
        wr(`GPE_LMASK_OFS, 32'h1);
        wr(`GPE_IMASK_OFS, 32'h2);
        for (int t = 1; t < 4; t++) begin
            wr(`GPE_RISE_OFS, 32'(t & 1));
            wr(`GPE_FALL_OFS, 32'(t >> 1));
            wr(`GPE_PEND_OFS, 32'hfffff);
            wr(`GPE_ISTAT_OFS, 32'h3);
            key <= 16'h0008;
            tick(6);
            chk({line_irq[0], irq}, {2{t[1]}});
            key <= 16'h0000;
            tick(6);
            rdc(`GPE_PEND_OFS, 32'h1, 32'hffffffff);
        end
        wr(`GPE_PEND_OFS, 32'h1);
        wr(`GPE_ISTAT_OFS, 32'h3);
        tick(2);
        chk({line_irq[0], irq}, 2'b00);
        wr(`GPE_LMASK_OFS, 32'h0);
        key <= 16'h0008;
        tick(6);
        chk({line_irq[0], irq}, 2'b00);
        rdc(`GPE_PEND_OFS, 32'h1, 32'hffffffff);
        key <= 16'h0000;
        wr(`GPE_SEL_LO_OFS, 32'h5);
        wr(`GPE_PEND_OFS, 32'hfffff);
        key <= 16'h0020;
        tick(6);
        rdc(`GPE_PEND_OFS, 32'h1, 32'hffffffff);
        key <= 16'h0000;
        // Let the release edge on line 0 land before the clear, or it sets pending again
        tick(6);
        wr(`GPE_PEND_OFS, 32'hfffff);
        wr(`GPE_RISE_OFS, 32'h20000);
        rtc <= 1'b1;
        tick(6);
        wr(`GPE_EMASK_OFS, 32'h80000);
        wr(`GPE_LMASK_OFS, 32'h80000);
        w0 = wakes;
        wr(`GPE_SWTRIG_OFS, 32'h80000);
        tick(2);
        chk(32'(line_irq[19]), 32'h1);
        chk(32'(wakes - w0), 32'h1);
        rdc(`GPE_PEND_OFS, 32'ha0000, 32'hffffffff);
        wr(`GPE_SWTRIG_OFS, 32'hffffffff);
        rdc(`GPE_PEND_OFS, 32'hfffff, 32'hffffffff);
        stop_test();
    end
endmodule
